// [inc/flash_burst_pkg.sv]
package flash_burst_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int CFG_W = 16;
  localparam int SYNC_DEPTH = 3;
  localparam int CLK_PERIOD_NS = 40;

  localparam logic [15:0] CFG_RESET = 16'h9CC3;
  localparam int CFG_MODE_BIT = 15;
  localparam int CFG_DELAY_LSB = 10;
  localparam int CFG_LEN_LSB = 0;
  localparam logic [3:0] DELAY_MAX_CODE = 4'h7;
  localparam logic [3:0] DELAY_LOAD_ADD = 4'h1;
  localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;

  typedef enum logic [1:0] {LINK_IDLE, LINK_WAIT, LINK_BURST} link_phase_e;

  typedef struct packed {
    logic [2:0] clr_sync;
    logic clr_act;
    logic [2:0] ack_sync;
    logic ack_lvl;
    logic req_tgl;
    logic [15:0] cfg;
    logic [15:0] hold_cnt;
    logic rb_n;
  } core_state_s;

  typedef struct packed {
    logic [2:0] clr_sync;
    logic clr_act;
    logic [2:0] req_sync;
    logic req_lvl;
    logic ack_tgl;
    logic [15:0] cfg;
    link_phase_e phase;
    logic [19:0] start;
    logic [19:0] arr;
    logic [2:0] cnt;
    logic [3:0] dly;
    logic [31:0] dq;
    logic eob_n;
  } link_state_s;

endpackage : flash_burst_pkg

// [src/flash_burst_read_reset.sv]
`timescale 1ns/1ps
module flash_burst_read_reset #(
  parameter int RESET_OP_NS = 20000
) (
  // core clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // host link
  input wire logic LINK_CLK_IN,
  input wire logic HW_CLEAR_N_IN,
  input wire logic CE_N_IN,
  input wire logic OE_N_IN,
  input wire logic ADV_N_IN,
  input wire logic [19:0] ADDR_IN,
  output logic [31:0] DQ_OUT,
  output logic DQ_OE_N_OUT,
  output logic EOB_N_OUT,
  output logic EOB_OE_N_OUT,
  output logic READY_BUSY_N_OUT,
  // array and register space, link clock
  output logic [19:0] ARRAY_ADDR_OUT,
  input wire logic [31:0] ARRAY_DATA_IN,
  input wire logic REG_READ_IN,
  input wire logic [31:0] REG_DATA_IN,
  // algorithm and configuration, core clock
  input wire logic ALGO_BUSY_IN,
  output logic ALGO_ABORT_OUT,
  input wire logic CFG_WR_IN,
  input wire logic [15:0] CFG_WDATA_IN,
  output logic CFG_READY_OUT,
  output logic [15:0] CFG_RDATA_OUT
);

  localparam int RESET_OP_CYC_I = (RESET_OP_NS + flash_burst_pkg::CLK_PERIOD_NS - 1)
                                  / flash_burst_pkg::CLK_PERIOD_NS;
  localparam logic [15:0] RESET_OP_CYC = 16'(RESET_OP_CYC_I);

  generate
    if (RESET_OP_CYC_I < 1 || RESET_OP_CYC_I > 65535) begin : g_bad_reset_op
      $error("RESET_OP_NS out of range");
    end
  endgenerate

  flash_burst_pkg::core_state_s c_reg;
  flash_burst_pkg::core_state_s c_next;
  flash_burst_pkg::link_state_s l_reg;
  flash_burst_pkg::link_state_s l_next;

  logic pending;
  logic sync_mode;
  logic [2:0] len_mask;
  logic [3:0] dly_code;
  logic [2:0] next_cnt;
  logic latch;
  logic quiet;

  // core domain: configuration, busy hold, clear
  always_comb begin
    c_next = c_reg;
    c_next.clr_sync = {c_reg.clr_sync[1:0], HW_CLEAR_N_IN};
    if (c_reg.clr_sync[2] == c_reg.clr_sync[1]) begin
      c_next.clr_act = ~c_reg.clr_sync[2];
    end
    c_next.ack_sync = {c_reg.ack_sync[1:0], l_reg.ack_tgl};
    if (c_reg.ack_sync[2] == c_reg.ack_sync[1]) begin
      c_next.ack_lvl = c_reg.ack_sync[2];
    end
    pending = c_reg.req_tgl != c_reg.ack_lvl;
    if (c_reg.clr_act) begin
      c_next.cfg = flash_burst_pkg::CFG_RESET;
    end else if (CFG_WR_IN && !ALGO_BUSY_IN && !pending) begin
      c_next.cfg = CFG_WDATA_IN;
      c_next.req_tgl = ~c_reg.req_tgl;
    end
    if (c_reg.clr_act && ALGO_BUSY_IN) begin
      c_next.hold_cnt = RESET_OP_CYC;
    end else if (c_reg.hold_cnt != 16'h0000) begin
      c_next.hold_cnt = c_reg.hold_cnt - 16'h0001;
    end
    c_next.rb_n = !(ALGO_BUSY_IN || c_next.hold_cnt != 16'h0000);
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      c_reg <= '{clr_sync: flash_burst_pkg::SYNC_IDLE_HIGH, clr_act: 1'b0,
                 ack_sync: 3'h0, ack_lvl: 1'b0, req_tgl: 1'b0,
                 cfg: flash_burst_pkg::CFG_RESET, hold_cnt: 16'h0000, rb_n: 1'b1};
    end else begin
      c_reg <= c_next;
    end
  end

  assign CFG_READY_OUT = !pending && !ALGO_BUSY_IN && !c_reg.clr_act;
  assign CFG_RDATA_OUT = c_reg.cfg;
  assign READY_BUSY_N_OUT = c_reg.rb_n;
  assign ALGO_ABORT_OUT = c_reg.clr_act;

  // link domain: burst sequencer
  always_comb begin
    l_next = l_reg;
    sync_mode = !l_reg.cfg[flash_burst_pkg::CFG_MODE_BIT];
    case (l_reg.cfg[flash_burst_pkg::CFG_LEN_LSB +: 2])
      2'h1: len_mask = 3'h1;
      2'h2: len_mask = 3'h3;
      default: len_mask = 3'h7;
    endcase
    dly_code = l_reg.cfg[flash_burst_pkg::CFG_DELAY_LSB +: 4];
    if (dly_code > flash_burst_pkg::DELAY_MAX_CODE) begin
      dly_code = flash_burst_pkg::DELAY_MAX_CODE;
    end
    next_cnt = (l_reg.cnt + 3'h1) & len_mask;
    latch = !CE_N_IN && !l_reg.clr_act && !REG_READ_IN && !ADV_N_IN && sync_mode;
    quiet = !CE_N_IN && ADV_N_IN && !REG_READ_IN && !l_reg.clr_act;
    l_next.clr_sync = {l_reg.clr_sync[1:0], HW_CLEAR_N_IN};
    if (l_reg.clr_sync[2] == l_reg.clr_sync[1]) begin
      l_next.clr_act = ~l_reg.clr_sync[2];
    end
    l_next.req_sync = {l_reg.req_sync[1:0], c_reg.req_tgl};
    if (l_reg.req_sync[2] == l_reg.req_sync[1] && l_reg.req_sync[2] != l_reg.req_lvl) begin
      l_next.req_lvl = l_reg.req_sync[2];
      l_next.ack_tgl = l_reg.req_sync[2];
      l_next.cfg = c_reg.cfg;
    end
    if (l_reg.clr_act) begin
      l_next.cfg = flash_burst_pkg::CFG_RESET;
      l_next.phase = flash_burst_pkg::LINK_IDLE;
      l_next.eob_n = 1'b1;
    end else if (CE_N_IN) begin
      l_next.phase = flash_burst_pkg::LINK_IDLE;
      l_next.eob_n = 1'b1;
    end else if (REG_READ_IN) begin
      l_next.phase = flash_burst_pkg::LINK_IDLE;
      l_next.dq = REG_DATA_IN;
      l_next.eob_n = 1'b1;
    end else if (latch) begin
      l_next.phase = flash_burst_pkg::LINK_WAIT;
      l_next.start = ADDR_IN;
      l_next.arr = ADDR_IN;
      l_next.cnt = 3'h0;
      l_next.dly = dly_code + flash_burst_pkg::DELAY_LOAD_ADD;
      l_next.eob_n = 1'b1;
    end else begin
      case (l_reg.phase)
        flash_burst_pkg::LINK_IDLE: begin
          if (!sync_mode) begin
            l_next.arr = ADDR_IN;
            l_next.dq = ARRAY_DATA_IN;
          end
        end
        flash_burst_pkg::LINK_WAIT: begin
          if (l_reg.dly == 4'h1) begin
            l_next.phase = flash_burst_pkg::LINK_BURST;
          end else begin
            l_next.dly = l_reg.dly - 4'h1;
          end
        end
        flash_burst_pkg::LINK_BURST: begin
        end
        default: begin
          l_next.phase = flash_burst_pkg::LINK_IDLE;
        end
      endcase
      if (l_reg.phase == flash_burst_pkg::LINK_BURST ||
          (l_reg.phase == flash_burst_pkg::LINK_WAIT && l_reg.dly == 4'h1)) begin
        l_next.dq = ARRAY_DATA_IN;
        l_next.eob_n = !(l_reg.cnt == len_mask);
        l_next.cnt = next_cnt;
        l_next.arr = {l_reg.start[19:3],
                      (l_reg.start[2:0] & ~len_mask) |
                      ((l_reg.start[2:0] + next_cnt) & len_mask)};
      end
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      l_reg <= '{clr_sync: flash_burst_pkg::SYNC_IDLE_HIGH, clr_act: 1'b0,
                 req_sync: 3'h0, req_lvl: 1'b0, ack_tgl: 1'b0,
                 cfg: flash_burst_pkg::CFG_RESET, phase: flash_burst_pkg::LINK_IDLE,
                 start: 20'h00000, arr: 20'h00000, cnt: 3'h0, dly: 4'h0,
                 dq: 32'h00000000, eob_n: 1'b1};
    end else begin
      l_reg <= l_next;
    end
  end

  assign ARRAY_ADDR_OUT = l_reg.arr;
  assign DQ_OUT = l_reg.dq;
  assign DQ_OE_N_OUT = OE_N_IN || CE_N_IN || !HW_CLEAR_N_IN || l_reg.clr_act;
  assign EOB_N_OUT = l_reg.eob_n;
  assign EOB_OE_N_OUT = OE_N_IN || !HW_CLEAR_N_IN;

  // checks
  AST_CLEAR_FLOAT: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !HW_CLEAR_N_IN |-> DQ_OE_N_OUT && EOB_OE_N_OUT)
    else $error("bus driven during clear");

  AST_CFG_DEFAULT: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    c_reg.clr_act |-> !CFG_READY_OUT ##1 c_reg.cfg == flash_burst_pkg::CFG_RESET)
    else $error("configuration not defaulted by clear");

  AST_BUSY_HOLD: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    c_reg.clr_act && ALGO_BUSY_IN |=> !READY_BUSY_N_OUT ##1 !READY_BUSY_N_OUT)
    else $error("ready_busy_n released too early");

  AST_CFG_IGNORED: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CFG_WR_IN && ALGO_BUSY_IN && !c_reg.clr_act |=> c_reg.cfg == $past(c_reg.cfg))
    else $error("configuration written while busy");

  AST_DELAY_MIN: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    (latch && dly_code == 4'h0) ##1 quiet |=> l_reg.phase == flash_burst_pkg::LINK_BURST)
    else $error("two-clock initial delay not met");

  AST_EOB_LAST: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST && quiet && l_reg.cnt == len_mask
    |=> !EOB_N_OUT ##1 (EOB_N_OUT || !quiet))
    else $error("end of burst indicator wrong");

  AST_WRAP_ORDER: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST
    |-> (l_reg.arr[2:0] & len_mask) == ((l_reg.start[2:0] + l_reg.cnt) & len_mask)
        && l_reg.arr[19:3] == l_reg.start[19:3])
    else $error("burst address outside wrap group");

  AST_CE_EXIT: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    CE_N_IN |-> DQ_OE_N_OUT ##1 l_reg.phase == flash_burst_pkg::LINK_IDLE)
    else $error("burst survived chip deselect");

  AST_OE_CONTINUE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    OE_N_IN && quiet && l_reg.phase == flash_burst_pkg::LINK_BURST
    |=> l_reg.phase == flash_burst_pkg::LINK_BURST && l_reg.cnt != $past(l_reg.cnt)
        || len_mask == 3'h0)
    else $error("output enable stalled burst");

  AST_ASYNC_AFTER_CLEAR: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.clr_act |=> l_reg.cfg[flash_burst_pkg::CFG_MODE_BIT] &&
        l_reg.phase == flash_burst_pkg::LINK_IDLE)
    else $error("burst mode kept after clear");

  AST_EOB_FLOAT: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    OE_N_IN |-> EOB_OE_N_OUT)
    else $error("indicator driven with output enable high");

  AST_EOB_DRIVE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    !OE_N_IN && HW_CLEAR_N_IN |-> !EOB_OE_N_OUT)
    else $error("indicator not driven with output enable low");

  AST_OE_FLOAT: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    OE_N_IN |-> DQ_OE_N_OUT)
    else $error("data bus driven with output enable high");

  AST_LATCH_START: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    latch |=> l_reg.phase == flash_burst_pkg::LINK_WAIT && l_reg.start == $past(ADDR_IN))
    else $error("burst address not latched");

  AST_RESTART: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST && latch |=> l_reg.cnt == 3'h0)
    else $error("new strobe did not restart burst");

  AST_REG_SINGLE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    !CE_N_IN && REG_READ_IN && !l_reg.clr_act
    |=> l_reg.phase == flash_burst_pkg::LINK_IDLE && DQ_OUT == $past(REG_DATA_IN))
    else $error("register read not single cycle");

  AST_ASYNC_NO_BURST: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.cfg[flash_burst_pkg::CFG_MODE_BIT] |-> !latch)
    else $error("burst started in asynchronous mode");

  AST_ASYNC_FOLLOW: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.cfg[flash_burst_pkg::CFG_MODE_BIT] && l_reg.phase == flash_burst_pkg::LINK_IDLE &&
    !CE_N_IN && !REG_READ_IN && !l_reg.clr_act |=> ARRAY_ADDR_OUT == $past(ADDR_IN))
    else $error("asynchronous read did not follow address");

  AST_WAIT_COUNT: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_WAIT && quiet && l_reg.dly != 4'h1
    |=> l_reg.phase == flash_burst_pkg::LINK_WAIT && l_reg.dly == $past(l_reg.dly) - 4'h1)
    else $error("wait state count wrong");

  AST_WAIT_DONE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_WAIT && quiet && l_reg.dly == 4'h1
    |=> l_reg.phase == flash_burst_pkg::LINK_BURST && DQ_OUT == $past(ARRAY_DATA_IN))
    else $error("first burst word missing");

  AST_BURST_DATA: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST && quiet |=> DQ_OUT == $past(ARRAY_DATA_IN))
    else $error("burst word not launched");

  AST_BURST_STEP: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST && quiet
    |=> l_reg.cnt == (($past(l_reg.cnt) + 3'h1) & $past(len_mask)))
    else $error("burst count did not wrap");

  AST_EOB_HIGH: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST && quiet && l_reg.cnt != len_mask |=> EOB_N_OUT)
    else $error("indicator low before final word");

  AST_IDLE_EOB: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_IDLE |-> EOB_N_OUT)
    else $error("indicator low outside burst");

  AST_CLEAR_DQ: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.clr_act |-> DQ_OE_N_OUT)
    else $error("data bus driven during clear");

  AST_LEN_RANGE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_BURST |-> (l_reg.cnt & ~len_mask) == 3'h0)
    else $error("burst count beyond length");

  AST_DELAY_LOAD: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    latch |=> l_reg.dly == $past(dly_code) + 4'h1)
    else $error("initial delay loaded wrong");

  AST_DELAY_RANGE: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
    l_reg.phase == flash_burst_pkg::LINK_WAIT |-> l_reg.dly <= 4'h8 && l_reg.dly != 4'h0)
    else $error("initial delay out of range");

  AST_CLEAR_SEEN: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !c_reg.clr_sync[2] && !c_reg.clr_sync[1] |=> ALGO_ABORT_OUT)
    else $error("clear not acted on");

  AST_CLEAR_GONE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    c_reg.clr_sync[2] && c_reg.clr_sync[1] |=> !ALGO_ABORT_OUT)
    else $error("abort kept after clear");

  AST_BUSY_FOLLOW: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    ALGO_BUSY_IN |=> !READY_BUSY_N_OUT)
    else $error("ready shown while busy");

  AST_READY_IDLE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !ALGO_BUSY_IN && c_reg.hold_cnt == 16'h0000 |=> READY_BUSY_N_OUT)
    else $error("busy shown while idle");

  AST_CFG_TAKEN: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CFG_WR_IN && CFG_READY_OUT |=> c_reg.cfg == $past(CFG_WDATA_IN))
    else $error("configuration write lost");

  AST_CFG_LOCK: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !CFG_READY_OUT && !c_reg.clr_act |=> c_reg.cfg == $past(c_reg.cfg))
    else $error("configuration changed while locked");

endmodule : flash_burst_read_reset

// [verif/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
  // array side, answers in the same cycle
  input wire logic [19:0] addr_in,
  output logic [31:0] data_out
);
  // each word carries its own address, so order errors show
  assign data_out = {12'hA50, addr_in};
endmodule : flash_array_model

// [verif/flash_burst_read_reset_tb.sv]
`timescale 1ns/1ps
module flash_burst_read_reset_tb;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic clr_n = 1'b1;
  logic ce_n = 1'b1;
  logic oe_n = 1'b1;
  logic adv_n = 1'b1;
  logic rreg = 1'b0;
  logic busy = 1'b0;
  logic cwr = 1'b0;
  logic [19:0] addr = 20'h0;
  logic [15:0] cwd = 16'h0;
  logic [31:0] rdat = 32'h0000ABCD;
  logic [31:0] dq, arr_d;
  logic [19:0] arr_a;
  logic [15:0] crd;
  logic dq_oe_n, eob_n, eob_oe_n, rb_n, abort, rdy;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] cv [3] = '{16'h0001, 16'h0402, 16'h1C03};
  logic [19:0] sa [3] = '{20'h00101, 20'h02341, 20'h0ABC3};
  int wl [3] = '{2, 4, 8};
  int dl [3] = '{2, 3, 9};

  always #20 clk = ~clk;
  initial begin
    #7;
    forever #80 lclk = ~lclk;
  end

  flash_array_model arr (.addr_in(arr_a), .data_out(arr_d));

  flash_burst_read_reset #(.RESET_OP_NS(200)) dut (
    .CLK_IN(clk), .NRST_IN(nrst), .LINK_CLK_IN(lclk), .HW_CLEAR_N_IN(clr_n),
    .CE_N_IN(ce_n), .OE_N_IN(oe_n), .ADV_N_IN(adv_n), .ADDR_IN(addr),
    .DQ_OUT(dq), .DQ_OE_N_OUT(dq_oe_n), .EOB_N_OUT(eob_n), .EOB_OE_N_OUT(eob_oe_n),
    .READY_BUSY_N_OUT(rb_n), .ARRAY_ADDR_OUT(arr_a), .ARRAY_DATA_IN(arr_d),
    .REG_READ_IN(rreg), .REG_DATA_IN(rdat), .ALGO_BUSY_IN(busy),
    .ALGO_ABORT_OUT(abort), .CFG_WR_IN(cwr), .CFG_WDATA_IN(cwd),
    .CFG_READY_OUT(rdy), .CFG_RDATA_OUT(crd)
  );

  function automatic logic [31:0] word(input logic [19:0] a);
    return {12'hA50, a};
  endfunction : word

  task complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task cfg_write(input logic [15:0] v);
    @(negedge clk);
    cwd = v;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk);
    check("cfg ready", 32'(rdy), 32'h1);
    check("cfg", 32'(crd), 32'(v));
    repeat (2) @(negedge lclk);
  endtask : cfg_write

  // strobe held low: only a burst-mode part would restart here
  task async_read;
    @(negedge lclk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    adv_n = 1'b0;
    addr = 20'h12345;
    repeat (3) @(posedge lclk);
    @(negedge lclk);
    check("async dq", dq, word(20'h12345));
    adv_n = 1'b1;
    ce_n = 1'b1;
  endtask : async_read

  task burst(input int k);
    logic [19:0] m;
    m = 20'(wl[k] - 1);
    @(negedge lclk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    adv_n = 1'b0;
    addr = sa[k];
    @(posedge lclk);
    @(negedge lclk);
    adv_n = 1'b1;
    repeat (dl[k] - 1) @(posedge lclk);
    for (int i = 0; i <= wl[k]; i++) begin
      @(negedge lclk);
      oe_n = 1'b0;
      #1;
      check("dq", dq, word((sa[k] & ~m) | ((sa[k] + 20'(i)) & m)));
      check("eob", 32'(eob_n), 32'((i % wl[k]) != wl[k] - 1));
      check("eob oe", 32'(eob_oe_n), 32'h0);
      if (i == 1) begin
        oe_n = 1'b1;
        #1;
        check("dq oe", 32'(dq_oe_n), 32'h1);
        check("eob oe", 32'(eob_oe_n), 32'h1);
      end
      @(posedge lclk);
    end
    @(negedge lclk);
    ce_n = 1'b1;
    #1;
    check("dq oe", 32'(dq_oe_n), 32'h1);
  endtask : burst

  task reg_read;
    @(negedge lclk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    rreg = 1'b1;
    repeat (2) @(posedge lclk);
    repeat (4) begin
      @(negedge lclk);
      check("reg dq", dq, rdat);
      @(posedge lclk);
    end
    @(negedge lclk);
    rreg = 1'b0;
    ce_n = 1'b1;
  endtask : reg_read

  task clear_busy;
    @(negedge clk);
    busy = 1'b1;
    cwd = 16'h0;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    repeat (3) @(negedge clk);
    check("cfg", 32'(crd), 32'h1C03);
    @(negedge lclk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    clr_n = 1'b0;
    #1;
    check("dq oe", 32'(dq_oe_n), 32'h1);
    repeat (5) @(negedge lclk);
    @(negedge clk);
    check("abort", 32'(abort), 32'h1);
    check("cfg", 32'(crd), 32'h9CC3);
    busy = 1'b0;
    clr_n = 1'b1;
    repeat (2) @(negedge clk);
    check("busy", 32'(rb_n), 32'h0);
    for (int i = 0; i < 40 && rb_n !== 1'b1; i++) @(negedge clk);
    check("busy", 32'(rb_n), 32'h1);
    ce_n = 1'b1;
    repeat (6) @(negedge lclk);
  endtask : clear_busy

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check("cfg", 32'(crd), 32'h9CC3);
    async_read();
    for (int k = 0; k < 3; k++) begin
      cfg_write(cv[k]);
      burst(k);
    end
    reg_read();
    clear_busy();
    async_read();
    complete_run();
  end
endmodule : flash_burst_read_reset_tb
